// file: hdl/axcu_bitmask.sv
// Purpose: mask of the low n bits for a run of discrete bits
// Assumes: count already checked to lie in 1..32
// Notes: counts of 32 and above give all ones
`timescale 1ns/1ps
module axcu_bitmask
  import axcu_pkg::*;
(
  input wire logic [CNT_W-1:0] i_count,
  output logic [ACC_W-1:0] o_mask
);

  // ==========================================================
  // mask
  always_comb begin
    if (i_count >= BITS_MAX) begin
      o_mask = '1;
    end else begin
      o_mask = (32'h00000001 << i_count) - 32'h00000001;
    end
  end

endmodule : axcu_bitmask

// file: hdl/axcu_cmp.sv
// Purpose: unsigned magnitude compare of two words
// Assumes: combinational, same clock domain as user
// Notes: exactly one output is high
`timescale 1ns/1ps
module axcu_cmp #(
  parameter int W = 16
) (
  input wire logic [W-1:0] i_a,
  input wire logic [W-1:0] i_b,
  output logic o_lt,
  output logic o_eq,
  output logic o_gt
);

  // ==========================================================
  // compare
  always_comb begin
    o_lt = i_a < i_b;
    o_eq = i_a == i_b;
    o_gt = i_a > i_b;
  end

endmodule : axcu_cmp

// file: hdl/axcu_unit.sv
// Purpose: accumulator xor and compare execution unit with status flags
// Assumes: requests from sequencer on i_ref_clk, one cycle each
// Notes: results and flags register at the edge after the request
//
// Functional notes
// - bit-run xor folds 1 to 32 discrete bits into the accumulator
// - bit-run start address limited per bank, count from a constant
// - zero flag follows whole accumulator after xor or compare
// - bit-run xor sets negative flag from accumulator top bit
// - stack xor folds the top stack level into the accumulator
// - stack xor pops the top level, remaining entries move up
// - stack xor updates zero and negative flags from its result
// - word compare uses low 16 accumulator bits against one word
// - equal flag set when compared value matches operand
// - greater flag set when compared value exceeds operand
// - less flag set when compared value is below operand
// - double compare uses full 32 bits against pair or constant
// - flags hold until the next instruction writing them
`timescale 1ns/1ps
module axcu_unit
  import axcu_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire axcu_req_t i_req,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [ACC_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [ACC_W-1:0] o_rdata,
  output logic [ACC_W-1:0] o_acc,
  output axcu_flags_t o_flags,
  output logic [STK_PTR_W-1:0] o_depth,
  output logic o_done,
  output logic o_reject,
  output logic o_irq
);

  // ==========================================================
  // state
  axcu_state_t st_ff;
  axcu_state_t nxt_st;
  logic [ACC_W-1:0] bits_mask;
  logic w_lt;
  logic w_eq;
  logic w_gt;
  logic d_lt;
  logic d_eq;
  logic d_gt;
  logic start_ok;
  logic count_ok;
  logic range_ok;
  logic [IRQ_W-1:0] events;
  logic [ACC_W-1:0] res;

  // ==========================================================
  // helpers
  axcu_bitmask u_mask (
    .i_count(i_req.count),
    .o_mask(bits_mask)
  );

  axcu_cmp #(.W(WORD_W)) u_cmp_word (
    .i_a(st_ff.acc[WORD_W-1:0]),
    .i_b(i_req.operand[WORD_W-1:0]),
    .o_lt(w_lt),
    .o_eq(w_eq),
    .o_gt(w_gt)
  );

  axcu_cmp #(.W(ACC_W)) u_cmp_double (
    .i_a(st_ff.acc),
    .i_b(i_req.operand),
    .o_lt(d_lt),
    .o_eq(d_eq),
    .o_gt(d_gt)
  );

  // ==========================================================
  // operand checks
  // start and count limits
  always_comb begin
    case (i_req.bank)
      bank_input, bank_output, bank_special: begin
        start_ok = i_req.start <= LIM_IO;
      end
      bank_relay, bank_stage: begin
        start_ok = i_req.start <= LIM_RELAY;
      end
      bank_timer: begin
        start_ok = i_req.start <= LIM_TIMER;
      end
      bank_counter: begin
        start_ok = i_req.start <= LIM_COUNTER;
      end
      default: begin
        start_ok = 1'b0;
      end
    endcase
    count_ok = (i_req.count >= BITS_MIN) && (i_req.count <= BITS_MAX);
    range_ok = start_ok && count_ok;
  end

  // ==========================================================
  // next state
  always_comb begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    nxt_st.reject = 1'b0;
    nxt_st.rd_data = '0;
    events = '0;
    res = '0;
    if (i_req.valid) begin
      case (i_req.op)
        load_push_op: begin
          nxt_st.acc = i_req.operand;
          for (int i = STK_DEPTH - 1; i > 0; i--) begin
            nxt_st.stack[i] = st_ff.stack[i-1];
          end
          nxt_st.stack[0] = st_ff.acc;
          if (st_ff.depth < STK_PTR_W'(STK_DEPTH)) begin
            nxt_st.depth = st_ff.depth + 4'h1;
          end
          nxt_st.done = 1'b1;
        end
        xor_bit_range_op: begin
          if (range_ok) begin
            res = st_ff.acc ^ (i_req.operand & bits_mask);
            nxt_st.acc = res;
            nxt_st.flags.zero_flag = res == '0;
            nxt_st.flags.negative_flag = res[ACC_W-1];
            nxt_st.done = 1'b1;
          end else begin
            nxt_st.reject = 1'b1;
          end
        end
        xor_stack_top_op: begin
          if (st_ff.depth != '0) begin
            res = st_ff.acc ^ st_ff.stack[0];
            nxt_st.acc = res;
            for (int i = 0; i < STK_DEPTH - 1; i++) begin
              nxt_st.stack[i] = st_ff.stack[i+1];
            end
            nxt_st.stack[STK_DEPTH-1] = '0;
            nxt_st.depth = st_ff.depth - 4'h1;
            nxt_st.flags.zero_flag = res == '0;
            nxt_st.flags.negative_flag = res[ACC_W-1];
            nxt_st.done = 1'b1;
          end else begin
            nxt_st.reject = 1'b1;
            events[IRQ_UNDER] = 1'b1;
          end
        end
        compare_word_op: begin
          nxt_st.flags.less_flag = w_lt;
          nxt_st.flags.equal_flag = w_eq;
          nxt_st.flags.greater_flag = w_gt;
          nxt_st.flags.zero_flag = st_ff.acc == '0;
          nxt_st.done = 1'b1;
        end
        compare_double_op: begin
          if (i_req.const_src && (i_req.operand > KMAX_DOUBLE)) begin
            nxt_st.reject = 1'b1;
          end else begin
            nxt_st.flags.less_flag = d_lt;
            nxt_st.flags.equal_flag = d_eq;
            nxt_st.flags.greater_flag = d_gt;
            nxt_st.flags.zero_flag = st_ff.acc == '0;
            nxt_st.done = 1'b1;
          end
        end
        default: begin
          nxt_st.reject = 1'b0;
        end
      endcase
    end
    events[IRQ_DONE] = nxt_st.done;
    events[IRQ_REJECT] = nxt_st.reject;
    // bus write, an op in the same cycle wins the accumulator
    if (i_wr) begin
      case (i_addr)
        OFS_ACC: begin
          if (!i_req.valid) begin
            nxt_st.acc = i_wdata;
          end
        end
        OFS_IRQ_STAT: begin
          nxt_st.irq_stat = st_ff.irq_stat & ~i_wdata[IRQ_W-1:0];
        end
        OFS_IRQ_MASK: begin
          nxt_st.irq_mask = i_wdata[IRQ_W-1:0];
        end
        default: begin
          nxt_st.irq_mask = nxt_st.irq_mask;
        end
      endcase
    end
    // set wins over clear
    nxt_st.irq_stat = nxt_st.irq_stat | events;
    nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_mask);
    if (i_rd) begin
      case (i_addr)
        OFS_ACC: nxt_st.rd_data = st_ff.acc;
        OFS_FLAGS: nxt_st.rd_data = {27'h0, st_ff.flags};
        OFS_IRQ_STAT: nxt_st.rd_data = {29'h0, st_ff.irq_stat};
        OFS_IRQ_MASK: nxt_st.rd_data = {29'h0, st_ff.irq_mask};
        OFS_DEPTH: nxt_st.rd_data = {28'h0000000, st_ff.depth};
        default: nxt_st.rd_data = '0;
      endcase
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_ff <= '0;
      st_ff.acc <= RST_ACC;
      st_ff.irq_mask <= RST_IRQ_MASK;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_rdata = st_ff.rd_data;
  assign o_acc = st_ff.acc;
  assign o_flags = st_ff.flags;
  assign o_depth = st_ff.depth;
  assign o_done = st_ff.done;
  assign o_reject = st_ff.reject;
  assign o_irq = st_ff.irq;

  // ==========================================================
  // assertions
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_xor_bits_go;
    i_req.valid && i_req.op == xor_bit_range_op && range_ok;
  endsequence

  sequence s_xor_stack_go;
    i_req.valid && i_req.op == xor_stack_top_op && st_ff.depth != '0;
  endsequence

  sequence s_cmp_go;
    i_req.valid && (i_req.op == compare_word_op ||
      (i_req.op == compare_double_op &&
       !(i_req.const_src && i_req.operand > KMAX_DOUBLE)));
  endsequence

  a_xor_bits_result: assert property (s_xor_bits_go |=>
    st_ff.acc == ($past(st_ff.acc) ^ ($past(i_req.operand) &
      $past(bits_mask))) && st_ff.done)
    else $error("bit-run xor result wrong");

  a_range_reject: assert property (i_req.valid &&
    i_req.op == xor_bit_range_op && !range_ok |=>
    st_ff.reject && !st_ff.done && $stable(st_ff.acc))
    else $error("bad bit run not refused");

  a_zero_flag: assert property (s_xor_bits_go or s_xor_stack_go or
    s_cmp_go |=> st_ff.flags.zero_flag == (st_ff.acc == '0))
    else $error("zero flag wrong");

  a_neg_flag: assert property (s_xor_bits_go or s_xor_stack_go |=>
    st_ff.flags.negative_flag == st_ff.acc[ACC_W-1])
    else $error("negative flag wrong");

  a_stack_result: assert property (s_xor_stack_go |=>
    st_ff.acc == ($past(st_ff.acc) ^ $past(st_ff.stack[0])))
    else $error("stack xor result wrong");

  a_stack_pop: assert property (s_xor_stack_go |=>
    st_ff.depth == $past(st_ff.depth) - 4'h1 &&
    st_ff.stack[0] == $past(st_ff.stack[1]))
    else $error("stack not popped");

  a_stack_flags: assert property (s_xor_stack_go |=>
    st_ff.flags.zero_flag == ($past(st_ff.acc) == $past(st_ff.stack[0])))
    else $error("stack xor zero flag wrong");

  a_cmp_word: assert property (i_req.valid &&
    i_req.op == compare_word_op |=>
    st_ff.flags.equal_flag ==
      ($past(st_ff.acc[WORD_W-1:0]) == $past(i_req.operand[WORD_W-1:0]))
    && st_ff.flags.less_flag ==
      ($past(st_ff.acc[WORD_W-1:0]) < $past(i_req.operand[WORD_W-1:0])))
    else $error("word compare flags wrong");

  a_cmp_double: assert property (i_req.valid &&
    i_req.op == compare_double_op && !i_req.const_src |=>
    st_ff.flags.greater_flag == ($past(st_ff.acc) > $past(i_req.operand))
    && st_ff.flags.equal_flag == ($past(st_ff.acc) == $past(i_req.operand)))
    else $error("double compare flags wrong");

  a_cmp_onehot: assert property (s_cmp_go ##1 !i_req.valid |->
    $onehot({st_ff.flags.less_flag, st_ff.flags.equal_flag,
      st_ff.flags.greater_flag}) && st_ff.acc == $past(st_ff.acc, 1) &&
    st_ff.done)
    else $error("compare result not one-hot or acc changed");

  a_flags_hold: assert property (!i_req.valid |=>
    $stable(st_ff.flags))
    else $error("flags changed without an instruction");

endmodule : axcu_unit

// file: pkg/axcu_pkg.sv
// Purpose: shared constants and types of the accumulator xor/compare unit
// Assumes: one clock, sequencer and operand fetch on the same clock
// Notes: bit runs arrive from operand fetch already aligned at bit 0
package axcu_pkg;

  // ==========================================================
  // widths and depths
  localparam int ACC_W = 32;
  localparam int WORD_W = 16;
  localparam int STK_DEPTH = 8;
  localparam int STK_PTR_W = 4;
  localparam int CNT_W = 6;
  localparam int START_W = 11;
  localparam int ADDR_W = 8;
  localparam int IRQ_W = 3;

  // ==========================================================
  // operand limits
  localparam logic [CNT_W-1:0] BITS_MIN = 6'h01;
  localparam logic [CNT_W-1:0] BITS_MAX = 6'h20;
  localparam logic [START_W-1:0] LIM_IO = 11'h1ff;
  localparam logic [START_W-1:0] LIM_RELAY = 11'h3ff;
  localparam logic [START_W-1:0] LIM_TIMER = 11'h0ff;
  localparam logic [START_W-1:0] LIM_COUNTER = 11'h07f;
  localparam logic [ACC_W-1:0] KMAX_DOUBLE = 32'h0fffffff;

  // ==========================================================
  // register offsets
  localparam logic [ADDR_W-1:0] OFS_ACC = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_DEPTH = 8'h10;

  // ==========================================================
  // interrupt status bit positions
  localparam int IRQ_DONE = 0;
  localparam int IRQ_REJECT = 1;
  localparam int IRQ_UNDER = 2;

  // ==========================================================
  // reset values
  localparam logic [ACC_W-1:0] RST_ACC = 32'h00000000;
  localparam logic [IRQ_W-1:0] RST_IRQ_MASK = 3'h0;

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    op_idle,
    load_push_op,
    xor_bit_range_op,
    xor_stack_top_op,
    compare_word_op,
    compare_double_op
  } axcu_op_t;

  typedef enum logic [2:0] {
    bank_input,
    bank_output,
    bank_relay,
    bank_stage,
    bank_timer,
    bank_counter,
    bank_special
  } axcu_bank_t;

  typedef struct packed {
    logic valid;
    axcu_op_t op;
    axcu_bank_t bank;
    logic [START_W-1:0] start;
    logic [CNT_W-1:0] count;
    logic const_src;
    logic [ACC_W-1:0] operand;
  } axcu_req_t;

  typedef struct packed {
    logic negative_flag;
    logic zero_flag;
    logic greater_flag;
    logic equal_flag;
    logic less_flag;
  } axcu_flags_t;

  typedef struct packed {
    logic [ACC_W-1:0] acc;
    logic [STK_DEPTH-1:0][ACC_W-1:0] stack;
    logic [STK_PTR_W-1:0] depth;
    axcu_flags_t flags;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [ACC_W-1:0] rd_data;
    logic done;
    logic reject;
    logic irq;
  } axcu_state_t;

endpackage : axcu_pkg

// file: sim/accumulator_xor_compare_unit_test.sv
// Purpose: self-checking bench of the xor and compare unit
// Assumes: seed 55138, bench drives at rising edge
// Notes: expected state kept by a reference model in the bench
`timescale 1ns/1ps
module accumulator_xor_compare_unit_test
  import axcu_pkg::*;
;
  logic i_ref_clk, i_sys_rst, i_wr, i_rd, o_done, o_reject, o_irq;
  logic [ADDR_W-1:0] i_addr;
  logic [ACC_W-1:0] i_wdata, o_rdata, o_acc;
  logic [STK_PTR_W-1:0] o_depth;
  axcu_req_t req;
  axcu_flags_t o_flags, m_fl;
  logic [ACC_W-1:0] m_acc;
  logic [ACC_W-1:0] m_stk [8];
  int m_dep, num_errors, checked, cyc;
  axcu_req_t r;

  axcu_seq_model seq (.i_ref_clk(i_ref_clk), .o_req(req));
  axcu_unit dut (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
    .i_req(req), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_acc(o_acc), .o_flags(o_flags),
    .o_depth(o_depth), .o_done(o_done), .o_reject(o_reject),
    .o_irq(o_irq));

  // ==========================================================
  // clock and timeout
  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      end_sim();
    end
  end

  // ==========================================================
  // helpers
  task automatic end_sim();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim

  task automatic chk(input string n, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask : chk

  task automatic cmp(input logic [31:0] a, b);
    m_fl.less_flag = a < b;
    m_fl.equal_flag = a == b;
    m_fl.greater_flag = a > b;
    m_fl.zero_flag = m_acc == 0;
  endtask : cmp

  task automatic model(input axcu_req_t q, output bit rej);
    logic [31:0] mk;
    mk = (q.count >= 32) ? '1 : (32'h1 << q.count) - 1;
    rej = 0;
    case (q.op)
      load_push_op: begin
        for (int i = 7; i > 0; i--) m_stk[i] = m_stk[i-1];
        m_stk[0] = m_acc;
        m_dep = (m_dep < 8) ? m_dep + 1 : 8;
        m_acc = q.operand;
      end
      xor_bit_range_op: begin
        rej = q.count == 0 || q.count > 32 || q.start > seq.lim(q.bank);
        if (!rej) m_acc = m_acc ^ (q.operand & mk);
      end
      xor_stack_top_op: begin
        rej = m_dep == 0;
        if (!rej) begin
          m_acc = m_acc ^ m_stk[0];
          for (int i = 0; i < 7; i++) m_stk[i] = m_stk[i+1];
          m_dep--;
        end
      end
      compare_word_op: cmp({16'h0, m_acc[15:0]}, {16'h0, q.operand[15:0]});
      compare_double_op: begin
        rej = q.const_src && q.operand > KMAX_DOUBLE;
        if (!rej) cmp(m_acc, q.operand);
      end
      default: ;
    endcase
    if (!rej && (q.op == xor_bit_range_op || q.op == xor_stack_top_op)) begin
      m_fl.zero_flag = m_acc == 0;
      m_fl.negative_flag = m_acc[31];
    end
  endtask : model

  task automatic run(input axcu_req_t q);
    bit rej;
    q.valid = 1'b1;
    model(q, rej);
    seq.send(q);
    #1;
    chk("reject", rej, o_reject);
    chk("done", !rej, o_done);
    chk("acc", m_acc, o_acc);
    chk("depth", m_dep, o_depth);
    chk("less", m_fl.less_flag, o_flags.less_flag);
    chk("equal", m_fl.equal_flag, o_flags.equal_flag);
    chk("greater", m_fl.greater_flag, o_flags.greater_flag);
    chk("zero", m_fl.zero_flag, o_flags.zero_flag);
    chk("negative", m_fl.negative_flag, o_flags.negative_flag);
  endtask : run

  task automatic op(input axcu_op_t o, input logic [31:0] v,
      input logic [5:0] n, input logic [10:0] s, input logic k);
    r = '0;
    r.op = o;
    r.operand = v;
    r.count = n;
    r.start = s;
    r.bank = bank_relay;
    r.const_src = k;
    run(r);
  endtask : op

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rd(input string n, input logic [7:0] a, logic [31:0] e);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1;
    chk(n, e, o_rdata);
  endtask : rd

  // ==========================================================
  // main sequence
  initial begin
    {i_wr, i_rd, i_addr, i_wdata} = '0;
    i_sys_rst = 1'b1;
    {m_acc, m_fl, m_dep, num_errors, checked, cyc} = '0;
    for (int i = 0; i < 8; i++) m_stk[i] = '0;
    void'($urandom(55138));
    repeat (6) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    rd("acc rst", OFS_ACC, RST_ACC);
    rd("mask rst", OFS_IRQ_MASK, 32'h0);
    rd("unmapped", 8'h14, 32'h0);
    op(xor_stack_top_op, 0, 0, 0, 0);
    for (int i = 0; i < 9; i++) op(load_push_op, $urandom, 0, 0, 0);
    op(xor_stack_top_op, 0, 0, 0, 0);
    op(xor_stack_top_op, 0, 0, 0, 0);
    op(xor_bit_range_op, '1, 0, 0, 0);
    op(xor_bit_range_op, '1, 1, 0, 0);
    op(xor_bit_range_op, '1, 6'h20, 11'h3ff, 0);
    op(xor_bit_range_op, '1, 6'h21, 0, 0);
    op(xor_bit_range_op, '1, 4, 11'h400, 0);
    r = '0;
    r.op = xor_bit_range_op;
    r.bank = bank_counter;
    r.start = 11'h080;
    r.count = 6'h08;
    r.operand = '1;
    run(r);
    op(load_push_op, 32'habcd1234, 0, 0, 0);
    op(compare_word_op, 32'h00001234, 0, 0, 0);
    op(compare_word_op, 32'hffff1235, 0, 0, 0);
    op(compare_double_op, 32'h10000000, 0, 0, 1);
    op(compare_double_op, 32'h0fffffff, 0, 0, 1);
    op(compare_double_op, 32'habcd1234, 0, 0, 0);
    op(xor_bit_range_op, 32'habcd1234, 6'h20, 0, 0);
    for (int i = 0; i < 300; i++) begin
      r = '0;
      r.op = axcu_op_t'(1 + $urandom % 5);
      r.bank = axcu_bank_t'($urandom % 7);
      r.start = $urandom & seq.lim(r.bank);
      r.count = 1 + $urandom % 32;
      r.const_src = $urandom;
      r.operand = $urandom;
      if (r.op == compare_double_op && r.const_src) r.operand[31:28] = 0;
      run(r);
    end
    rd("flags", OFS_FLAGS, {27'h0, m_fl});
    rd("depth", OFS_DEPTH, m_dep);
    rd("irq stat", OFS_IRQ_STAT, 32'h7);
    wr(OFS_IRQ_MASK, 32'h1);
    repeat (2) @(posedge i_ref_clk);
    #1 chk("irq on", 1, o_irq);
    wr(OFS_IRQ_STAT, 32'h7);
    repeat (2) @(posedge i_ref_clk);
    #1 chk("irq off", 0, o_irq);
    rd("irq clr", OFS_IRQ_STAT, 32'h0);
    wr(OFS_ACC, 32'h5a5a0001);
    rd("acc wr", OFS_ACC, 32'h5a5a0001);
    end_sim();
  end
endmodule : accumulator_xor_compare_unit_test

// file: sim/axcu_seq_model.sv
// Purpose: sequencer and operand fetch model feeding unit requests
// Assumes: one request at a time, changed just after a rising edge
// Notes: bank start limits offered to the bench for legal bit runs
`timescale 1ns/1ps
module axcu_seq_model
  import axcu_pkg::*;
(
  input wire logic i_ref_clk,
  output axcu_req_t o_req
);
  initial o_req = '0;
  // ==========================================================
  // bank start limits
  // start range per bank
  function automatic logic [START_W-1:0] lim(input axcu_bank_t b);
    case (b)
      bank_relay, bank_stage: lim = LIM_RELAY;
      bank_timer: lim = LIM_TIMER;
      bank_counter: lim = LIM_COUNTER;
      default: lim = LIM_IO;
    endcase
  endfunction : lim
  // ==========================================================
  // request issue
  // caller samples flags before next send
  task automatic send(input axcu_req_t r);
    @(posedge i_ref_clk);
    o_req <= r;
    @(posedge i_ref_clk);
    o_req.valid <= 1'b0;
  endtask : send
endmodule : axcu_seq_model
